// file: core/mlc_params.svh
/*
 * Constants of the multiturn limit counter: register offsets, field
 * positions, reset values, codes and timing.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef MLC_PARAMS_SVH
`define MLC_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define MLC_OFS_LIMIT 8'h00
`define MLC_OFS_PROTECT 8'h04
`define MLC_OFS_UTIL_CMD 8'h08
`define MLC_OFS_RESTART 8'h0c
`define MLC_OFS_STATUS 8'h10
`define MLC_OFS_ACTIVE 8'h14
`define MLC_OFS_ENC_LIMIT 8'h18
`define MLC_OFS_REV_COUNT 8'h1c
`define MLC_OFS_LAST 8'h1c
`define MLC_WORD_MASK 8'hfc

// Command bits of the utility command and restart registers.
`define MLC_CMD_ENTER 0
`define MLC_CMD_EXECUTE 1
`define MLC_CMD_RETURN 2
`define MLC_CMD_RESTART 0

// Status register fields.
`define MLC_ST_ALARM 0
`define MLC_ST_DONE 1
`define MLC_ST_NOOP 2
`define MLC_ST_OPEN 3
`define MLC_ST_ABS 4
`define MLC_ST_CODE_LSB 8

// Reset values and codes.
`define MLC_LIMIT_RESET 16'hffff
`define MLC_FULL_SPAN 16'hffff
`define MLC_PROTECT_RESET 16'h0000
`define MLC_PROTECT_ON 16'h0001
`define MLC_ALARM_CODE 8'hee
`define MLC_NO_CODE 8'h00
`define MLC_RESP_OKAY 2'b00
`define MLC_RESP_SLVERR 2'b10

// Timing: completion indication time and the clock rate.
`define MLC_CLK_HZ 25000000
`define MLC_DONE_TIME_MS 1000
`define MLC_DONE_CYCLES (`MLC_DONE_TIME_MS * (`MLC_CLK_HZ / 1000))

`endif

// file: core/mlc_pkg.sv
/*
 * Types and shared functions of the multiturn limit counter.
 * Assumes nothing of its surroundings.
 */
package mlc_pkg;

    // States of the limit-write utility.
    typedef enum logic [1:0] {UT_IDLE, UT_OPEN, UT_WRITE, UT_DONE} mlc_util_state_t;

    // A multiturn limit or revolution count.
    typedef logic [15:0] mlc_word16_t;

    // Merges the two low byte lanes of a write into a 16-bit register.
    function automatic mlc_word16_t mlc_merge16(input mlc_word16_t old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        mlc_word16_t res;
        res[7:0] = strb[0] ? data[7:0] : old[7:0];
        res[15:8] = strb[1] ? data[15:8] : old[15:8];
        return res;
    endfunction

endpackage

// file: core/mlc_rev_counter.sv
/*
 * Revolution counter that wraps between zero and a multiturn limit.
 * Assumes step pulses of one cycle, synchronous to aclk.
 */
`timescale 1ns/100ps
`include "mlc_params.svh"

module mlc_rev_counter
    import mlc_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Revolution steps and the limit in force.
    input wire logic fwd_step,
    input wire logic rev_step,
    input wire logic [W-1:0] limit,
    // Current count.
    output logic [W-1:0] count_q
);

    // Counts whole revolutions and wraps at both ends of the span.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else if (fwd_step && !rev_step) begin
            if (count_q >= limit) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + W'(1);
            end
        end else if (rev_step && !fwd_step) begin
            if (count_q == '0 || count_q > limit) begin
                count_q <= limit;
            end else begin
                count_q <= count_q - W'(1);
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rev_wraps_up: assert property (rev_step && !fwd_step && count_q == '0 |=> count_q == $past(limit)) else $error("Reverse step at zero did not load the limit.");
    a_fwd_wraps_zero: assert property (fwd_step && !rev_step && count_q == limit |=> count_q == '0) else $error("Forward step at the limit did not clear the count.");
    a_fwd_counts_up: assert property (fwd_step && !rev_step && count_q < limit |=> count_q == $past(count_q) + W'(1)) else $error("Forward step did not add one.");
    a_rev_counts_down: assert property (rev_step && !fwd_step && count_q != '0 && count_q <= limit |=> count_q == $past(count_q) - W'(1)) else $error("Reverse step did not take one.");
    a_idle_holds: assert property (fwd_step == rev_step |=> $stable(count_q)) else $error("Count moved without a single step.");

endmodule

// file: core/mlc_util_fsm.sv
/*
 * Limit-write utility sequencer: entry, execute or return, completion time.
 * Assumes one-cycle command pulses and a level protect input.
 */
`timescale 1ns/100ps
`include "mlc_params.svh"

module mlc_util_fsm
    import mlc_pkg::*;
#(
    parameter int DONE_CYCLES = `MLC_DONE_CYCLES
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Operator commands and protection.
    input wire logic enter,
    input wire logic execute,
    input wire logic ret,
    input wire logic protect_on,
    // Indications and encoder write strobe.
    output logic open_q,
    output logic done_q,
    output logic noop_q,
    output logic wr_stb_q
);

    mlc_util_state_t state_q;
    mlc_util_state_t state_d;
    logic [31:0] timer_q;

    // Next state of the utility.
    always_comb begin
        state_d = state_q;
        case (state_q)
            UT_IDLE: begin
                if (enter && !protect_on) begin
                    state_d = UT_OPEN;
                end
            end
            UT_OPEN: begin
                if (execute) begin
                    state_d = UT_WRITE;
                end else if (ret) begin
                    state_d = UT_IDLE;
                end
            end
            UT_WRITE: begin
                state_d = UT_DONE;
            end
            UT_DONE: begin
                if (timer_q == 32'h0000_0000) begin
                    state_d = UT_IDLE;
                end
            end
            default: begin
                state_d = UT_IDLE;
            end
        endcase
    end

    // State register and the flags derived from the next state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= UT_IDLE;
            open_q <= 1'b0;
            done_q <= 1'b0;
            wr_stb_q <= 1'b0;
        end else begin
            state_q <= state_d;
            open_q <= state_d != UT_IDLE;
            done_q <= state_d == UT_DONE;
            wr_stb_q <= state_d == UT_WRITE;
        end
    end

    // Completion timer, loaded as the done indication starts.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_q <= 32'h0000_0000;
        end else if (state_d == UT_DONE && state_q != UT_DONE) begin
            timer_q <= 32'(DONE_CYCLES - 1);
        end else if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
        end
    end

    // No-operation indication after a refused entry, cleared by a later entry.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            noop_q <= 1'b0;
        end else if (enter && state_q == UT_IDLE) begin
            noop_q <= protect_on;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_exec_in_open;
        state_q == UT_OPEN && execute;
    endsequence

    sequence s_write_then_done;
        wr_stb_q ##1 (done_q && !wr_stb_q);
    endsequence

    a_exec_writes: assert property (s_exec_in_open |=> s_write_then_done) else $error("Execute did not write and then show done.");
    a_done_start: assert property ($rose(done_q) |-> timer_q == 32'(DONE_CYCLES - 1)) else $error("Done indication started with a wrong time.");
    a_done_holds: assert property (done_q && timer_q != 32'h0000_0000 |=> done_q) else $error("Done indication ended early.");
    a_done_ends: assert property (done_q && timer_q == 32'h0000_0000 |=> !done_q && !open_q) else $error("Done indication overran.");
    a_protect_refuses: assert property (state_q == UT_IDLE && enter && protect_on |=> noop_q && !open_q) else $error("Protected entry was not refused.");
    a_return_no_write: assert property (state_q == UT_OPEN && ret && !execute |=> !wr_stb_q ##1 !wr_stb_q && !done_q) else $error("Return wrote the encoder.");

endmodule

// file: core/mlc_top.sv
/*
 * Multiturn limit counter top: AXI4-Lite register slave, limit capture at
 * restart, mismatch alarm, revolution counter and limit-write utility.
 * Assumes one clock, synchronous inputs, and an encoder that reports its
 * stored limit as a level and accepts a new one on a one-cycle strobe.
 */
`timescale 1ns/100ps
`include "mlc_params.svh"

module mlc_top
    import mlc_pkg::*;
#(
    parameter int DONE_CYCLES = `MLC_DONE_CYCLES
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read.
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Encoder side.
    input wire logic abs_encoder_present,
    input wire logic rev_fwd_step,
    input wire logic rev_rev_step,
    input wire logic [15:0] enc_stored_limit,
    output logic [15:0] enc_limit_wr_data,
    output logic enc_limit_wr_stb,
    // Position and alarm outputs.
    output logic [15:0] rev_count,
    output logic limit_mismatch_alarm,
    output logic [7:0] alarm_code
);

    mlc_word16_t multiturn_limit_value_q;
    mlc_word16_t write_protect_setting_q;
    mlc_word16_t active_limit_q;
    mlc_word16_t enc_limit_q;
    mlc_word16_t eff_limit;
    logic abs_q;
    logic boot_q;
    logic restart_q;
    logic enter_q;
    logic execute_q;
    logic return_q;
    logic util_open;
    logic util_done;
    logic util_noop;
    logic aw_held_q;
    logic aw_held_d;
    logic w_held_q;
    logic w_held_d;
    logic bvalid_d;
    logic rvalid_d;
    logic do_write;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] rd_word;

    // True for a word offset inside the register map.
    function automatic logic mlc_mapped(input logic [7:0] addr);
        return addr[1:0] == 2'b00 && addr <= `MLC_OFS_LAST;
    endfunction

    // Handshake bookkeeping for both AXI channels.
    always_comb begin
        do_write = aw_held_q && w_held_q && !bvalid;
        aw_held_d = do_write ? 1'b0 : (aw_held_q || (awvalid && awready));
        w_held_d = do_write ? 1'b0 : (w_held_q || (wvalid && wready));
        bvalid_d = do_write ? 1'b1 : (bvalid && !bready);
        rvalid_d = (arvalid && arready) ? 1'b1 : (rvalid && !rready);
    end

    // Write channel: address and data taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `MLC_RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready <= !aw_held_d && !bvalid_d;
            wready <= !w_held_d && !bvalid_d;
            bvalid <= bvalid_d;
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                bresp <= mlc_mapped(aw_addr_q) ? `MLC_RESP_OKAY : `MLC_RESP_SLVERR;
            end
        end
    end

    // Read word mux; write-only and reserved bits read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (araddr & `MLC_WORD_MASK)
            `MLC_OFS_LIMIT: rd_word[15:0] = multiturn_limit_value_q;
            `MLC_OFS_PROTECT: rd_word[15:0] = write_protect_setting_q;
            `MLC_OFS_STATUS: begin
                rd_word[`MLC_ST_ALARM] = limit_mismatch_alarm;
                rd_word[`MLC_ST_DONE] = util_done;
                rd_word[`MLC_ST_NOOP] = util_noop;
                rd_word[`MLC_ST_OPEN] = util_open;
                rd_word[`MLC_ST_ABS] = abs_q;
                rd_word[`MLC_ST_CODE_LSB +: 8] = alarm_code;
            end
            `MLC_OFS_ACTIVE: rd_word[15:0] = active_limit_q;
            `MLC_OFS_ENC_LIMIT: rd_word[15:0] = enc_limit_q;
            `MLC_OFS_REV_COUNT: rd_word[15:0] = rev_count;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `MLC_RESP_OKAY;
        end else begin
            arready <= !rvalid_d;
            rvalid <= rvalid_d;
            if (arvalid && arready) begin
                rdata <= rd_word;
                rresp <= mlc_mapped(araddr) ? `MLC_RESP_OKAY : `MLC_RESP_SLVERR;
            end
        end
    end

    // Stored settings written by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            multiturn_limit_value_q <= `MLC_LIMIT_RESET;
            write_protect_setting_q <= `MLC_PROTECT_RESET;
        end else if (do_write) begin
            if (aw_addr_q == `MLC_OFS_LIMIT) begin
                multiturn_limit_value_q <= mlc_merge16(multiturn_limit_value_q, w_data_q,
                                                       w_strb_q);
            end
            if (aw_addr_q == `MLC_OFS_PROTECT) begin
                write_protect_setting_q <= mlc_merge16(write_protect_setting_q, w_data_q,
                                                       w_strb_q);
            end
        end
    end

    // Command pulses, one cycle each, from writes to the command registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enter_q <= 1'b0;
            execute_q <= 1'b0;
            return_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            enter_q <= do_write && aw_addr_q == `MLC_OFS_UTIL_CMD && w_strb_q[0]
                       && w_data_q[`MLC_CMD_ENTER];
            execute_q <= do_write && aw_addr_q == `MLC_OFS_UTIL_CMD && w_strb_q[0]
                         && w_data_q[`MLC_CMD_EXECUTE];
            return_q <= do_write && aw_addr_q == `MLC_OFS_UTIL_CMD && w_strb_q[0]
                        && w_data_q[`MLC_CMD_RETURN];
            restart_q <= do_write && aw_addr_q == `MLC_OFS_RESTART && w_strb_q[0]
                         && w_data_q[`MLC_CMD_RESTART];
        end
    end

    // Limits in force are taken only just after reset or on a restart.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_q <= 1'b1;
            active_limit_q <= `MLC_LIMIT_RESET;
            enc_limit_q <= `MLC_LIMIT_RESET;
        end else begin
            boot_q <= 1'b0;
            if (boot_q || restart_q) begin
                active_limit_q <= multiturn_limit_value_q;
                enc_limit_q <= enc_stored_limit;
            end
        end
    end

    // Encoder type, sampled so the limit choice changes on a clean edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abs_q <= 1'b0;
        end else begin
            abs_q <= abs_encoder_present;
        end
    end

    // Without an absolute encoder the full 16-bit span is used.
    assign eff_limit = abs_q ? active_limit_q : `MLC_FULL_SPAN;

    // Alarm, with an absolute encoder, while the drive setting and the encoder limit taken at the last restart disagree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            limit_mismatch_alarm <= 1'b0;
            alarm_code <= `MLC_NO_CODE;
        end else if (abs_q && multiturn_limit_value_q != enc_limit_q) begin
            limit_mismatch_alarm <= 1'b1;
            alarm_code <= `MLC_ALARM_CODE;
        end else begin
            limit_mismatch_alarm <= 1'b0;
            alarm_code <= `MLC_NO_CODE;
        end
    end

    // Value offered to the encoder is the drive's current setting.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enc_limit_wr_data <= `MLC_LIMIT_RESET;
        end else begin
            enc_limit_wr_data <= multiturn_limit_value_q;
        end
    end

    // Revolution count within the limit in force.
    mlc_rev_counter #(
        .W(16)
    ) u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .fwd_step(rev_fwd_step),
        .rev_step(rev_rev_step),
        .limit(eff_limit),
        .count_q(rev_count)
    );

    // Limit-write utility, refused while write protection is set.
    mlc_util_fsm #(
        .DONE_CYCLES(DONE_CYCLES)
    ) u_util (
        .aclk(aclk),
        .aresetn(aresetn),
        .enter(enter_q),
        .execute(execute_q),
        .ret(return_q),
        .protect_on(write_protect_setting_q == `MLC_PROTECT_ON),
        .open_q(util_open),
        .done_q(util_done),
        .noop_q(util_noop),
        .wr_stb_q(enc_limit_wr_stb)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_limit_default: assert property ($rose(aresetn) |-> multiturn_limit_value_q == 16'hffff && active_limit_q == 16'hffff) else $error("Limit did not start at 65535.");
    a_no_abs_span: assert property (!abs_q |-> eff_limit == 16'hffff ##1 !limit_mismatch_alarm) else $error("Limit acted without an absolute encoder.");
    a_alarm_raised: assert property (abs_q && multiturn_limit_value_q != enc_limit_q |=> limit_mismatch_alarm && alarm_code == 8'hee) else $error("Mismatch gave no alarm.");
    a_alarm_cleared: assert property (abs_q && multiturn_limit_value_q == enc_limit_q |=> !limit_mismatch_alarm && alarm_code == 8'h00) else $error("Alarm without mismatch.");
    a_wr_data_match: assert property (enc_limit_wr_stb |-> enc_limit_wr_data == multiturn_limit_value_q || $changed(multiturn_limit_value_q)) else $error("Encoder got a stale limit.");
    a_alarm_persists: assert property (limit_mismatch_alarm && enc_limit_wr_stb && !restart_q && $stable(multiturn_limit_value_q) |=> limit_mismatch_alarm [*2]) else $error("Alarm cleared before restart.");
    a_restart_only: assert property (!boot_q && !restart_q |=> $stable(active_limit_q) && $stable(enc_limit_q)) else $error("Limit took effect without restart.");
    a_restart_takes: assert property (restart_q |=> active_limit_q == $past(multiturn_limit_value_q)) else $error("Restart did not apply the limit.");
    a_signed_wrap_up: assert property (eff_limit == 16'hffff && rev_fwd_step && !rev_rev_step && rev_count == 16'h7fff |=> rev_count == 16'h8000) else $error("Signed count did not pass +32767 to -32768.");
    a_signed_wrap_dn: assert property (eff_limit == 16'hffff && rev_rev_step && !rev_fwd_step && rev_count == 16'h8000 |=> rev_count == 16'h7fff) else $error("Signed count did not pass -32768 to +32767.");
    a_write_answer: assert property (awvalid && awready && wvalid && wready && !aw_held_q && !w_held_q |=> ##[1:2] bvalid) else $error("Write was not answered in time.");

endmodule

// file: tb/mlc_enc_model.sv
/*
 * Absolute encoder model: keeps the stored multiturn limit.
 * Assumes a one-cycle write strobe synchronous to aclk.
 */
`timescale 1ns/100ps

module mlc_enc_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Limit write from the drive.
    input wire logic [15:0] wr_data,
    input wire logic wr_stb,
    // Stored limit as a level.
    output logic [15:0] stored_q
);
    // The stored limit changes only on a write strobe; it starts at full span.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stored_q <= 16'hffff;
        end else if (wr_stb) begin
            stored_q <= wr_data;
        end
    end
endmodule

// file: tb/mlc_top_tb.sv
/*
 * Self-checking bench of the multiturn limit counter over AXI4-Lite reads and write responses.
 * Assumes the encoder model in its own file and a short completion time.
 */
`timescale 1ns/100ps

module mlc_top_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, abs_on = 1, fwd = 0, rvs = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, stb, alarm;
    logic [1:0] bresp, rresp;
    logic [15:0] enc_lim, wr_data, cnt;
    logic [7:0] code;
    logic [33:0] exp_q[$], msk_q[$];
    logic [1:0] bexp_q[$];
    int error_cnt = 0, num_checks = 0, cyc = 0, n;

    // Clock at 25 MHz.
    always #20 aclk = ~aclk;

    mlc_top #(.DONE_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .abs_encoder_present(abs_on), .rev_fwd_step(fwd),
        .rev_rev_step(rvs), .enc_stored_limit(enc_lim), .enc_limit_wr_data(wr_data),
        .enc_limit_wr_stb(stb), .rev_count(cnt), .limit_mismatch_alarm(alarm),
        .alarm_code(code));

    mlc_enc_model enc (.aclk(aclk), .aresetn(aresetn), .wr_data(wr_data), .wr_stb(stb),
        .stored_q(enc_lim));

    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp,
                       input logic [33:0] m);
        num_checks++;
        if ((seen & m) !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen & m);
        end
    endtask

    // Takes the oldest note whenever read data or a write response is handed over.
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) chk("read resp_data", {rresp, rdata},
            exp_q.pop_front(), msk_q.pop_front());
        if (bvalid === 1'b1 && bready === 1'b1) chk("write resp", {32'h0, bresp},
            {32'h0, bexp_q.pop_front()}, 34'h3);
    end

    // Cuts a hang short.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic idle(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] eb = 2'b00);
        logic ad, wd;
        ad = 0;
        wd = 0;
        bexp_q.push_back(eb);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                ad = 1;
                awvalid <= 0;
            end
            if (wvalid && wready === 1'b1) begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
        idle(4);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e,
                      input logic [33:0] m = 34'h3ffffffff);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
        @(posedge aclk);
    endtask

    task automatic step(input logic f, input int k);
        repeat (k) begin
            fwd <= f;
            rvs <= !f;
            @(posedge aclk);
            fwd <= 0;
            rvs <= 0;
            @(posedge aclk);
        end
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'h0ba72c4a));
        idle(10);
        aresetn <= 1;
        idle(3);
        rd(8'h00, 34'h0ffff);
        rd(8'h04, 34'h00000);
        rd(8'h10, 34'h00010);
        rd(8'h20, {2'b10, 32'h0});
        wr(8'h20, 32'h1, 2'b10);
        wr(8'h00, 32'd99);
        rd(8'h10, 34'h0ee11);
        rd(8'h14, 34'h0ffff);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h1);
        rd(8'h10, 34'h0ee15);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h1);
        rd(8'h10, 34'h0ee19);
        wr(8'h08, 32'h4);
        wr(8'h0c, 32'h1);
        rd(8'h18, 34'h0ffff);
        wr(8'h08, 32'h1);
        wr(8'h08, 32'h2);
        rd(8'h10, 34'h2, 34'h2);
        idle(30);
        rd(8'h10, 34'h0ee11);
        rd(8'h18, 34'h0ffff);
        wr(8'h0c, 32'h1);
        rd(8'h18, 34'd99);
        rd(8'h14, 34'd99);
        rd(8'h10, 34'h00010);
        step(0, 1);
        rd(8'h1c, 34'd99);
        step(1, 1);
        rd(8'h1c, 34'd0);
        n = $urandom_range(60, 1);
        step(1, n);
        rd(8'h1c, 34'(n));
        abs_on <= 0;
        idle(3);
        step(0, n + 1);
        rd(8'h1c, 34'h0ffff);
        rd(8'h10, 34'h00000);
        step(1, 1);
        rd(8'h1c, 34'h00000);
        finish_test();
    end
endmodule
